// ---- efe_pkg.sv ----
// Package for the event filter engine: constants, encodings and the filter entry type
package efe_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100000000;
   localparam int SEC_S = 1;
   localparam int SEC_CYCLES = CLK_HZ * SEC_S;

   // ------------------------------------------------------------
   // Startup delays, in seconds
   // ------------------------------------------------------------
   localparam logic [7:0] FILT_DLY_RST = 8'h3C;
   localparam logic [7:0] DLY_MIN = 8'h3C;
   localparam logic [7:0] ALRT_DLY_RST = 8'h3C;

   // ------------------------------------------------------------
   // Filter table
   // ------------------------------------------------------------
   localparam int NUM_FILT = 8;
   localparam logic [3:0] POL_MIN = 4'h1;
   localparam logic [3:0] POL_MAX = 4'hF;

   // Chassis action selector
   typedef enum logic [2:0] {
      EFE_ACT_NONE  = 3'h0,
      EFE_ACT_PDOWN = 3'h1,
      EFE_ACT_PCYC  = 3'h2,
      EFE_ACT_RST   = 3'h3,
      EFE_ACT_DIAG  = 3'h4
   } efe_act_t;

   // Preloaded event classes, one per filter slot
   localparam logic [7:0] EVT_TEMP = 8'h01;
   localparam logic [7:0] EVT_VOLT = 8'h02;
   localparam logic [7:0] EVT_FAN = 8'h04;
   localparam logic [7:0] EVT_PSU = 8'h08;
   localparam logic [7:0] EVT_BOOT_CODE = 8'h0F;
   localparam logic [7:0] EVT_BFR = 8'h10;
   localparam logic [7:0] EVT_WDOG = 8'h23;
   localparam logic [7:0] EVT_RESTART = 8'h1D;
   // Event class used for reports of taken actions
   localparam logic [7:0] EVT_ACTION = 8'hC0;

   // One filter entry
   typedef struct packed {
      logic en;
      logic alert_en;
      efe_act_t act;
      logic [3:0] policy;
   } efe_filt_t;

   localparam efe_filt_t FILT_RST = '{en: 1'b0, alert_en: 1'b0,
      act: EFE_ACT_NONE, policy: 4'h0};

endpackage

// ---- efe_engine.sv ----
// Event filter engine: matches events and raises chassis actions and alerts
// Functional notes
// (RULE1) Every event is checked against all filters
// (RULE2) Global filtering enable gates whole engine
// (RULE3) Logging option reports each started action
// (RULE4) Filtering held off 60..255 s after reset
// (RULE5) Alerts held off 60..255 s, zero none
// (RULE6) Action needs filter selection and global enable
// (RULE7) Four global enables for the chassis actions
// (RULE8) Global alert enable gates all alerts
// (RULE9) Entry: enable, alert flag, action, policy
// (RULE10) Table preloaded with eight disabled entries
// (RULE11) Alert needs entry flag and global enable
// (RULE12) Policy 1..15 when entry alerting enabled
// (RULE13) Action is one of five choices
// (RULE14) One-second tick counts; held-off events dropped
module efe_engine
#(
   parameter int SEC_CYC = efe_pkg::SEC_CYCLES
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Global settings and holdoff lengths
   input wire logic filt_glb_en,
   input wire logic log_act_en,
   input wire logic [7:0] filt_dly_cfg,
   input wire logic [7:0] alrt_dly_cfg,
   input wire logic glb_pcyc_en,
   input wire logic glb_rst_en,
   input wire logic glb_pdown_en,
   input wire logic glb_diag_en,
   input wire logic glb_alert_en,
   // Filter entry write
   input wire logic cfg_we,
   input wire logic [2:0] cfg_idx,
   input wire logic cfg_en,
   input wire logic cfg_alert_en,
   input wire logic [2:0] cfg_act,
   input wire logic [3:0] cfg_policy,
   // Incoming events
   input wire logic evt_valid,
   input wire logic [7:0] evt_type,
   // Write status, chassis actions and alerts
   output logic cfg_err,
   output logic act_pcyc,
   output logic act_rst,
   output logic act_pdown,
   output logic act_diag,
   output logic alert_req,
   output logic [3:0] alert_policy,
   // Reports of taken actions
   output logic log_valid,
   output logic [7:0] log_type,
   output logic [7:0] log_data,
   // Holdoff state
   output logic filt_ready,
   output logic alrt_ready
);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Refuse settings the logic cannot serve
   if (SEC_CYC < 1)
   begin : g_chk
      $error("SEC_CYC must be at least one");
   end

   // Slot classes and the 3-bit index are laid out for eight slots
   if (efe_pkg::NUM_FILT != 8)
   begin : g_chk_slots
      $error("NUM_FILT must be eight");
   end

   // Fixed event class of each preloaded slot
   localparam logic [7:0] SLOT_EVT [efe_pkg::NUM_FILT] = '{
      efe_pkg::EVT_TEMP, efe_pkg::EVT_VOLT, efe_pkg::EVT_FAN,
      efe_pkg::EVT_PSU, efe_pkg::EVT_BOOT_CODE, efe_pkg::EVT_BFR,
      efe_pkg::EVT_WDOG, efe_pkg::EVT_RESTART};

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      // Filter table and one-second divider
      efe_pkg::efe_filt_t [efe_pkg::NUM_FILT-1:0] tbl;
      logic [31:0] tick_cnt;
      // Startup holdoff counters and flags
      logic [7:0] filt_sec;
      logic [7:0] alrt_sec;
      logic filt_rdy;
      logic alrt_rdy;
      // Registered outputs
      logic cfg_err;
      logic pcyc;
      logic rst;
      logic pdown;
      logic diag;
      logic alert;
      logic [3:0] pol;
      logic log_v;
      logic [7:0] log_t;
      logic [7:0] log_d;
   } efe_state_t;

   // Registered state and its next value
   efe_state_t s_q;
   efe_state_t s_d;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Actions and alerts are one-cycle pulses; the first matching
   // alerting entry supplies the policy number.
   // A write and an event in one cycle: the event sees the old table.
   always_comb
   begin
      logic tick;
      logic [7:0] fdly;
      logic [7:0] adly;
      logic hit_any;
      logic alert_hit;
      logic [3:0] pol_sel;
      logic want_pcyc;
      logic want_rst;
      logic want_pdown;
      logic want_diag;
      efe_pkg::efe_filt_t e;
      tick = 1'b0;
      fdly = 8'h00;
      adly = 8'h00;
      hit_any = 1'b0;
      alert_hit = 1'b0;
      pol_sel = 4'h0;
      want_pcyc = 1'b0;
      want_rst = 1'b0;
      want_pdown = 1'b0;
      want_diag = 1'b0;
      e = efe_pkg::FILT_RST;
      s_d = s_q;
      s_d.pcyc = 1'b0;
      s_d.rst = 1'b0;
      s_d.pdown = 1'b0;
      s_d.diag = 1'b0;
      s_d.alert = 1'b0;
      s_d.log_v = 1'b0;

      // One-second tick divider
      // Both holdoffs share it, counting from the end of reset
      if (s_q.tick_cnt == 32'(SEC_CYC - 1))
      begin
         s_d.tick_cnt = 32'h0;
         tick = 1'b1; // RULE14
      end
      else
      begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h1;
      end

      // Filtering delay: values below the minimum are raised to it
      fdly = (filt_dly_cfg < efe_pkg::DLY_MIN) ? efe_pkg::DLY_MIN
         : filt_dly_cfg; // RULE4
      if (!s_q.filt_rdy && tick)
      begin
         s_d.filt_sec = s_q.filt_sec + 8'h01;
         if (s_d.filt_sec >= fdly)
         begin
            s_d.filt_rdy = 1'b1; // RULE4
         end
      end

      // Alert delay: zero means alerts are free at once
      adly = (alrt_dly_cfg < efe_pkg::DLY_MIN) ? efe_pkg::DLY_MIN
         : alrt_dly_cfg; // RULE5
      if (alrt_dly_cfg == 8'h00)
      begin
         s_d.alrt_rdy = 1'b1; // RULE5
      end
      else if (!s_q.alrt_rdy && tick)
      begin
         s_d.alrt_sec = s_q.alrt_sec + 8'h01;
         if (s_d.alrt_sec >= adly)
         begin
            s_d.alrt_rdy = 1'b1; // RULE5
         end
      end

      // Table write; a bad policy or action refuses the write
      // so a half-valid entry never reaches the match logic
      if (cfg_we)
      begin
         if ((cfg_alert_en && (cfg_policy < efe_pkg::POL_MIN ||
            cfg_policy > efe_pkg::POL_MAX)) ||
            cfg_act > 3'(efe_pkg::EFE_ACT_DIAG))
         begin
            s_d.cfg_err = 1'b1; // RULE12 RULE13
         end
         else
         begin
            s_d.cfg_err = 1'b0;
            s_d.tbl[cfg_idx].en = cfg_en; // RULE9
            s_d.tbl[cfg_idx].alert_en = cfg_alert_en;
            s_d.tbl[cfg_idx].act = efe_pkg::efe_act_t'(cfg_act);
            s_d.tbl[cfg_idx].policy = cfg_policy;
         end
      end

      // Match every filter; held-off or disabled events are dropped
      if (evt_valid && filt_glb_en && s_q.filt_rdy) // RULE2 RULE14
      begin
         // Walking down leaves the lowest alerting slot's policy
         for (int i = efe_pkg::NUM_FILT - 1; i >= 0; i--)
         begin
            e = s_q.tbl[i];
            if (e.en && evt_type == SLOT_EVT[i]) // RULE1
            begin
               hit_any = 1'b1;
               // RULE6 RULE7 RULE13
               want_pcyc = want_pcyc | (e.act == efe_pkg::EFE_ACT_PCYC);
               want_rst = want_rst | (e.act == efe_pkg::EFE_ACT_RST);
               want_pdown = want_pdown |
                  (e.act == efe_pkg::EFE_ACT_PDOWN);
               want_diag = want_diag | (e.act == efe_pkg::EFE_ACT_DIAG);
               if (e.alert_en)
               begin
                  alert_hit = 1'b1;
                  pol_sel = e.policy;
               end
            end
         end
      end

      // Global gating of actions and alerts
      // Alerts also wait out their own holdoff; actions do not
      s_d.pcyc = want_pcyc & glb_pcyc_en; // RULE6 RULE7
      s_d.rst = want_rst & glb_rst_en; // RULE7
      s_d.pdown = want_pdown & glb_pdown_en; // RULE7
      s_d.diag = want_diag & glb_diag_en; // RULE7
      s_d.alert = hit_any & alert_hit & glb_alert_en &
         s_q.alrt_rdy; // RULE8 RULE11 RULE5
      if (s_d.alert)
      begin
         s_d.pol = pol_sel;
      end

      // Report of started actions as a new event
      // It carries the gated actions, not the wishes
      if (log_act_en && (s_d.pcyc | s_d.rst | s_d.pdown | s_d.diag))
      begin
         s_d.log_v = 1'b1; // RULE3
         s_d.log_t = efe_pkg::EVT_ACTION;
         s_d.log_d = {4'h0, s_d.diag, s_d.pdown, s_d.rst, s_d.pcyc};
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Synchronous reset only; every output is a flop of this record
   // Table reset is the preloaded, fully disabled set
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         for (int i = 0; i < efe_pkg::NUM_FILT; i++)
         begin
            s_q.tbl[i] <= efe_pkg::FILT_RST; // RULE10
         end
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Write status
   assign cfg_err = s_q.cfg_err;

   // Chassis actions and alert request, one-cycle pulses
   assign act_pcyc = s_q.pcyc;
   assign act_rst = s_q.rst;
   assign act_pdown = s_q.pdown;
   assign act_diag = s_q.diag;
   assign alert_req = s_q.alert;
   assign alert_policy = s_q.pol;

   // Action report
   assign log_valid = s_q.log_v;
   assign log_type = s_q.log_t;
   assign log_data = s_q.log_d;

   // Holdoff state
   assign filt_ready = s_q.filt_rdy;
   assign alrt_ready = s_q.alrt_rdy;

endmodule

// ---- efe_engine_properties.sv ----
// Port checker for the event filter engine
module efe_engine_properties
#(
   parameter int SEC_CYC = 10
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic filt_glb_en,
   input wire logic log_act_en,
   input wire logic glb_pcyc_en,
   input wire logic glb_rst_en,
   input wire logic glb_pdown_en,
   input wire logic glb_diag_en,
   input wire logic glb_alert_en,
   input wire logic evt_valid,
   input wire logic act_pcyc,
   input wire logic act_rst,
   input wire logic act_pdown,
   input wire logic act_diag,
   input wire logic alert_req,
   input wire logic [3:0] alert_policy,
   input wire logic log_valid,
   input wire logic [7:0] log_type,
   input wire logic [7:0] log_data,
   input wire logic filt_ready,
   input wire logic alrt_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] up_q;
   logic [3:0] acts;
   logic go;
   assign acts = {act_diag, act_pdown, act_rst, act_pcyc};
   assign go = evt_valid && filt_glb_en && filt_ready;
   // Cycles since reset, saturating so it never wraps
   always_ff @(posedge sys_clk)
      if (sys_rst)
         up_q <= 32'h0;
      else if (!up_q[31])
         up_q <= up_q + 32'h1;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_pcyc_gate: assert property (act_pcyc |->
      $past(go && glb_pcyc_en))
      else $error("power cycle without cause");
   a_rst_gate: assert property (act_rst |-> $past(go && glb_rst_en))
      else $error("reset without cause");
   a_pdown_gate: assert property (act_pdown |->
      $past(go && glb_pdown_en))
      else $error("power down without cause");
   a_diag_gate: assert property (act_diag |->
      $past(go && glb_diag_en))
      else $error("diag interrupt without cause");
   a_alert_gate: assert property (alert_req |->
      $past(go && glb_alert_en))
      else $error("alert without cause");
   a_alert_hold: assert property (alert_req |-> alrt_ready)
      else $error("alert during holdoff");
   a_policy_set: assert property (alert_req |-> alert_policy != 4'h0)
      else $error("alert with empty policy");
   a_log_follow: assert property ($past(log_act_en) && acts != 4'h0 |->
      log_valid && log_type == 8'hC0 && log_data == {4'h0, acts})
      else $error("action not reported");
   a_log_cause: assert property (log_valid |-> acts != 4'h0)
      else $error("report without action");
   a_filt_hold: assert property (filt_ready |->
      up_q >= 32'(60 * SEC_CYC))
      else $error("filtering ready too early");
   a_ready_stays: assert property (filt_ready |=> filt_ready)
      else $error("ready dropped");
   c_action: cover property (act_pcyc);
   c_alert: cover property (alert_req);
   c_log: cover property (log_valid);
endmodule
bind efe_engine efe_engine_properties #(.SEC_CYC(SEC_CYC)) u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .filt_glb_en(filt_glb_en),
   .log_act_en(log_act_en), .glb_pcyc_en(glb_pcyc_en),
   .glb_rst_en(glb_rst_en), .glb_pdown_en(glb_pdown_en),
   .glb_diag_en(glb_diag_en), .glb_alert_en(glb_alert_en),
   .evt_valid(evt_valid), .act_pcyc(act_pcyc), .act_rst(act_rst),
   .act_pdown(act_pdown), .act_diag(act_diag), .alert_req(alert_req),
   .alert_policy(alert_policy), .log_valid(log_valid),
   .log_type(log_type), .log_data(log_data), .filt_ready(filt_ready),
   .alrt_ready(alrt_ready));

// ---- efe_evt_src.sv ----
// Event source model: turns a slot number into a one-cycle event
module efe_evt_src
(
   input wire logic sys_clk,
   input wire logic send,
   input wire logic [2:0] slot,
   output logic evt_valid,
   output logic [7:0] evt_type
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CLS [8] = '{efe_pkg::EVT_TEMP, efe_pkg::EVT_VOLT,
      efe_pkg::EVT_FAN, efe_pkg::EVT_PSU, efe_pkg::EVT_BOOT_CODE,
      efe_pkg::EVT_BFR, efe_pkg::EVT_WDOG, efe_pkg::EVT_RESTART};
   initial evt_type = 8'h5A;
   // Idle class toggles so nothing leans on a stale value
   always @(posedge sys_clk)
   begin
      evt_valid <= send;
      evt_type <= send ? CLS[slot] : ~evt_type;
   end
endmodule

// ---- efe_engine_tb_top.sv ----
// Testbench for the event filter engine
module efe_engine_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic filt_glb_en = 1'b1;
   logic log_act_en = 1'b1;
   logic [7:0] filt_dly_cfg = 8'h3C;
   logic [7:0] alrt_dly_cfg = 8'h46;
   logic [4:0] ge = 5'h1F;
   logic [11:0] cf = 12'h000;
   logic cfg_we = 1'b0;
   logic send = 1'b0;
   logic [2:0] slot = 3'h0;
   logic evt_valid, cfg_err, act_pcyc, act_rst, act_pdown, act_diag;
   logic alert_req, log_valid, filt_ready, alrt_ready;
   logic [3:0] alert_policy;
   logic [7:0] evt_type, log_type, log_data;
   logic [3:0] m [5] = '{4'h0, 4'h4, 4'h1, 4'h2, 4'h8};
   int err_count = 0;
   int samples_checked = 0;
   always #5 sys_clk = ~sys_clk;
   efe_evt_src src (.sys_clk(sys_clk), .send(send), .slot(slot),
      .evt_valid(evt_valid), .evt_type(evt_type));
   efe_engine #(.SEC_CYC(10)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .filt_glb_en(filt_glb_en), .log_act_en(log_act_en),
      .filt_dly_cfg(filt_dly_cfg), .alrt_dly_cfg(alrt_dly_cfg),
      .glb_pcyc_en(ge[0]), .glb_rst_en(ge[1]), .glb_pdown_en(ge[2]),
      .glb_diag_en(ge[3]), .glb_alert_en(ge[4]), .cfg_we(cfg_we),
      .cfg_idx(cf[11:9]), .cfg_en(cf[8]), .cfg_alert_en(cf[7]),
      .cfg_act(cf[6:4]), .cfg_policy(cf[3:0]), .evt_valid(evt_valid),
      .evt_type(evt_type), .cfg_err(cfg_err), .act_pcyc(act_pcyc),
      .act_rst(act_rst), .act_pdown(act_pdown), .act_diag(act_diag),
      .alert_req(alert_req), .alert_policy(alert_policy),
      .log_valid(log_valid), .log_type(log_type), .log_data(log_data),
      .filt_ready(filt_ready), .alrt_ready(alrt_ready));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask
   // Entry write: {index, enable, alert, action, policy}
   task automatic wr(input logic [11:0] c);
      @(posedge sys_clk);
      cfg_we <= 1'b1;
      cf <= c;
      @(posedge sys_clk);
      cfg_we <= 1'b0;
      #1;
   endtask
   // Event from a slot; answer lands two edges after the request
   task automatic ev(input logic [2:0] s, input logic [3:0] a,
      input logic al);
      @(posedge sys_clk);
      send <= 1'b1;
      slot <= s;
      @(posedge sys_clk);
      send <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({act_diag, act_pdown, act_rst, act_pcyc}, a);
      chk(alert_req, al);
      chk(log_valid, log_act_en && a != 4'h0);
      // Report contents only mean something while the report stands
      if (log_act_en && a != 4'h0)
      begin
         chk(log_type, efe_pkg::EVT_ACTION);
         chk(log_data, {4'h0, a});
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 1420 cycles the tests need
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      give_verdict;
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wr({3'h3, 2'h3, 3'h2, 4'h5});
      ev(3'h3, 4'h0, 1'b0);
      // Filtering opens on the sixtieth tick, 600 cycles after release
      repeat (594) @(posedge sys_clk);
      #1;
      chk(filt_ready, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(filt_ready, 1'b1);
      ev(3'h3, 4'h1, 1'b0);
      // Alerts open on the seventieth tick
      repeat (96) @(posedge sys_clk);
      #1;
      chk(alrt_ready, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(alrt_ready, 1'b1);
      ev(3'h3, 4'h1, 1'b1);
      chk(alert_policy, 4'h5);
      for (int s = 0; s < 8; s++)
         if (s != 3)
            ev(3'(s), 4'h0, 1'b0);
      for (int a = 0; a < 5; a++)
      begin
         wr({3'h5, 2'h2, 3'(a), 4'h0});
         ev(3'h5, m[a], 1'b0);
         @(posedge sys_clk);
         ge <= ~{1'b0, m[a]};
         ev(3'h5, 4'h0, 1'b0);
         @(posedge sys_clk);
         ge <= 5'h1F;
      end
      @(posedge sys_clk);
      ge[4] <= 1'b0;
      ev(3'h3, 4'h1, 1'b0);
      @(posedge sys_clk);
      ge <= 5'h1F;
      log_act_en <= 1'b0;
      ev(3'h3, 4'h1, 1'b1);
      @(posedge sys_clk);
      filt_glb_en <= 1'b0;
      log_act_en <= 1'b1;
      ev(3'h3, 4'h0, 1'b0);
      @(posedge sys_clk);
      filt_glb_en <= 1'b1;
      wr({3'h3, 2'h3, 3'h3, 4'h0});
      chk(cfg_err, 1'b1);
      ev(3'h3, 4'h1, 1'b1);
      wr({3'h3, 2'h2, 3'h5, 4'h0});
      chk(cfg_err, 1'b1);
      ev(3'h3, 4'h1, 1'b1);
      wr({3'h3, 2'h0, 3'h2, 4'h5});
      chk(cfg_err, 1'b0);
      ev(3'h3, 4'h0, 1'b0);
      wr({3'h0, 2'h2, 3'h2, 4'h0});
      ev(3'h0, 4'h1, 1'b0);
      // Second reset in mid-run: no alert holdoff, short filter setting
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      alrt_dly_cfg <= 8'h00;
      filt_dly_cfg <= 8'h0A;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      chk(alrt_ready, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(alrt_ready, 1'b1);
      chk(filt_ready, 1'b0);
      // A setting below sixty seconds is held at sixty
      repeat (598) @(posedge sys_clk);
      #1;
      chk(filt_ready, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(filt_ready, 1'b1);
      ev(3'h0, 4'h0, 1'b0);
      give_verdict;
   end
endmodule
